// File: common/cieb_pkg.sv
// Constants and types for the interrupt-enable and byte-load core slice.
// Assumes one 100 MHz clock; one T-state is one clock cycle.
package cieb_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TW = 5;
  // T-state counts per instruction form
  localparam logic [TW-1:0] T_REG = 5'h04;
  localparam logic [TW-1:0] T_IMM = 5'h07;
  localparam logic [TW-1:0] T_IND = 5'h07;
  localparam logic [TW-1:0] T_IMM_HL = 5'h0A;
  localparam logic [TW-1:0] T_DIR = 5'h0D;
  localparam logic [TW-1:0] T_SPEC = 5'h09;
  localparam logic [TW-1:0] T_RETURN_FROM_NONMASKABLE = 5'h0E;
  localparam logic [TW-1:0] T_IDX = 5'h13;
  localparam logic [TW-1:0] T_CTRL = 5'h04;
  // Remaining-count values that place the memory strobe and the finish
  localparam logic [TW-1:0] CNT_MEM = 5'h03;
  localparam logic [TW-1:0] CNT_LAST = 5'h01;
  // Opcode bytes
  localparam logic [7:0] OP_PFX_ED = 8'hED;
  localparam logic [7:0] OP_PFX_X = 8'hDD;
  localparam logic [7:0] OP_PFX_Y = 8'hFD;
  localparam logic [7:0] OP_ACC_VEC = 8'h57;
  localparam logic [7:0] OP_ACC_REF = 8'h5F;
  localparam logic [7:0] OP_VEC_ACC = 8'h47;
  localparam logic [7:0] OP_REF_ACC = 8'h4F;
  localparam logic [7:0] OP_RETURN_FROM_NONMASKABLE = 8'h45;
  localparam logic [7:0] OP_DI = 8'hF3;
  localparam logic [7:0] OP_EI = 8'hFB;
  localparam logic [7:0] OP_ACC_DIR = 8'h3A;
  localparam logic [7:0] OP_DIR_ACC = 8'h32;
  localparam logic [7:0] OP_ACC_BC = 8'h0A;
  localparam logic [7:0] OP_ACC_DE = 8'h1A;
  localparam logic [7:0] OP_BC_ACC = 8'h02;
  localparam logic [7:0] OP_DE_ACC = 8'h12;
  localparam logic [7:0] OP_MEM_IMM = 8'h36;
  localparam logic [1:0] GRP_MOVE = 2'h1;
  localparam logic [1:0] GRP_ZERO = 2'h0;
  // Register field codes
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  // Flag bit positions and reset values
  localparam int F_S = 7;
  localparam int F_Z = 6;
  localparam int F_H = 4;
  localparam int F_PV = 2;
  localparam int F_N = 1;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] PEND_MAX = 4'hF;

  typedef enum logic [3:0] {
    K_BAD = 4'b0000,
    K_REG = 4'b0001,
    K_REGF = 4'b0010,
    K_LOAD = 4'b0011,
    K_STORE = 4'b0100,
    K_SETV = 4'b0101,
    K_SETR = 4'b0110,
    K_DI = 4'b0111,
    K_EI = 4'b1000,
    K_RETURN_FROM_NONMASKABLE = 4'b1001
  } cieb_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_ACK = 2'b10
  } cieb_state_t;

  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } cieb_instr_t;

  typedef struct packed {
    cieb_kind_t kind;
    logic [2:0] dst;
    logic [7:0] val;
    logic [15:0] addr;
    logic [TW-1:0] tst;
    logic [1:0] m1s;
  } cieb_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cieb_mem_t;
endpackage : cieb_pkg

// File: hdl/cieb_intff.sv
// Interrupt enable flip-flops and the pending-request queue.
// Assumes request inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module cieb_intff (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nmi_req,
  input wire logic int_req,
  input wire logic di_exec,
  input wire logic ei_exec,
  input wire logic return_from_nonmaskable_exec,
  input wire logic nmi_take,
  input wire logic int_take,
  output logic nmi_pend_q,
  output logic [3:0] int_cnt_q,
  output logic primary_int_enable_q,
  output logic secondary_int_enable_q
);
  // A request in the same cycle as a take stays queued
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= nmi_req | (nmi_pend_q & ~nmi_take); // [RULE4]
    end
  end

  // Counted so several maskable requests are served one by one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_cnt_q <= 4'h0;
    end else if (int_req && !int_take && int_cnt_q != cieb_pkg::PEND_MAX) begin
      int_cnt_q <= int_cnt_q + 4'h1; // [RULE4]
    end else if (!int_req && int_take && int_cnt_q != 4'h0) begin
      int_cnt_q <= int_cnt_q - 4'h1; // [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      primary_int_enable_q <= 1'b0; // [RULE5]
      secondary_int_enable_q <= 1'b0; // [RULE5]
    end else if (nmi_take) begin
      // An enable change ending at this boundary lands before the copy
      secondary_int_enable_q <= return_from_nonmaskable_exec ? secondary_int_enable_q :
        (primary_int_enable_q | ei_exec) & ~di_exec; // [RULE6]
      primary_int_enable_q <= 1'b0; // [RULE6]
    end else if (int_take || di_exec) begin
      primary_int_enable_q <= 1'b0; // [RULE5]
      secondary_int_enable_q <= 1'b0; // [RULE5]
    end else if (ei_exec) begin
      primary_int_enable_q <= 1'b1; // [RULE5]
      secondary_int_enable_q <= 1'b1; // [RULE5]
    end else if (return_from_nonmaskable_exec) begin
      primary_int_enable_q <= secondary_int_enable_q; // [RULE7]
    end
  end
endmodule : cieb_intff

// File: hdl/cieb_core.sv
// Byte-load decode and execute slice with interrupt enable handling.
// Assumes whole instructions arrive as one bundle and memory answers a
// read strobe with data on the following cycle.
// How it works
// RULE1: Peripherals pass priority enable down the chain.
// RULE2: First chain device tied high, highest priority.
// RULE3: Requester holds chain output low until served.
// RULE4: Pending and new interrupts stay queued, never lost; code queues at most 15 maskable and one nonmaskable request.
// RULE5: Reset and disable clear both enables; enable sets.
// RULE6: Nonmaskable accept copies primary to secondary, clears.
// RULE7: Return-from-nonmaskable restores primary from secondary.
// RULE8: Accumulator from vector sets S,Z,PV; clears H,N.
// RULE9: Accumulator from refresh: same flag effects.
// RULE10: ED 57 is accumulator from vector, 9 states.
// RULE11: ED 5F is accumulator from refresh, 9 states.
// RULE12: ED 47 loads vector register, no flags.
// RULE13: ED 4F loads refresh register, 9 states.
// RULE14: Register move 4 states; immediate load 7.
// RULE15: Register field codes B,C,D,E,H,L,A.
// RULE16: Store via pointer pair; first index form 19.
// RULE17: Second index loads: FD, opcode, displacement, 19.
// RULE18: Opcode 3A direct address load, 13 states.
`timescale 1ns/1ps
module cieb_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire cieb_pkg::cieb_instr_t instr,
  input wire logic instr_valid,
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] second_index_register,
  input wire logic [7:0] mem_rdata,
  input wire logic nmi_req,
  input wire logic int_req,
  output logic instr_ready_q,
  output logic done_q,
  output logic illegal_q,
  output cieb_pkg::cieb_mem_t mem_q,
  output logic nmi_ack_q,
  output logic int_ack_q,
  output logic [7:0][7:0] gpr_q,
  output logic [7:0] flags_q,
  output logic [7:0] vector_reg_q,
  output logic [7:0] refresh_reg_q,
  output logic primary_int_enable_q,
  output logic secondary_int_enable_q
);
  cieb_pkg::cieb_state_t state_q;
  cieb_pkg::cieb_op_t op_d;
  cieb_pkg::cieb_op_t op_q;
  logic [cieb_pkg::TW-1:0] cnt_q;
  logic take;
  logic last;
  logic nmi_pend;
  logic [3:0] int_cnt;
  logic irq_go;
  logic nmi_take;
  logic int_take;
  logic [7:0] res;
  logic [15:0] base;
  logic [15:0] ea;
  logic [15:0] ptr;

  assign take = (state_q == cieb_pkg::S_IDLE) & instr_ready_q & instr_valid;
  assign last = (state_q == cieb_pkg::S_EXEC) & (cnt_q == cieb_pkg::CNT_LAST);
  // Interrupts are sampled only at an instruction boundary
  // A disable that ends here already masks this boundary
  assign irq_go = nmi_pend | ((int_cnt != 4'h0) & primary_int_enable_q &
    ~(last & (op_q.kind == cieb_pkg::K_DI))); // [RULE5]
  assign nmi_take = irq_go & nmi_pend &
    (last | ((state_q == cieb_pkg::S_IDLE) & ~instr_valid));
  assign int_take = irq_go & ~nmi_pend &
    (last | ((state_q == cieb_pkg::S_IDLE) & ~instr_valid));
  assign base = (instr.b0 == cieb_pkg::OP_PFX_X) ? first_index_register
                                                 : second_index_register;
  assign ea = base + {{8{instr.b2[7]}}, instr.b2};
  assign ptr = {gpr_q[cieb_pkg::REG_H], gpr_q[cieb_pkg::REG_L]};

  cieb_intff u_intff (
    .clk(clk),
    .rst_n(rst_n),
    .nmi_req(nmi_req),
    .int_req(int_req),
    .di_exec(last && op_q.kind == cieb_pkg::K_DI),
    .ei_exec(last && op_q.kind == cieb_pkg::K_EI),
    .return_from_nonmaskable_exec(last && op_q.kind == cieb_pkg::K_RETURN_FROM_NONMASKABLE),
    .nmi_take(nmi_take),
    .int_take(int_take),
    .nmi_pend_q(nmi_pend),
    .int_cnt_q(int_cnt),
    .primary_int_enable_q(primary_int_enable_q),
    .secondary_int_enable_q(secondary_int_enable_q)
  );

  always_comb begin
    op_d = '0;
    op_d.kind = cieb_pkg::K_BAD;
    op_d.tst = cieb_pkg::T_CTRL;
    op_d.m1s = 2'h1;
    if (instr.b0 == cieb_pkg::OP_PFX_X || instr.b0 == cieb_pkg::OP_PFX_Y) begin
      op_d.m1s = 2'h2;
      op_d.addr = ea;
      if (instr.b1 == cieb_pkg::OP_MEM_IMM) begin
        op_d.kind = cieb_pkg::K_STORE;
        op_d.val = instr.b3;
        op_d.tst = cieb_pkg::T_IDX;
      end else if (instr.b1[7:6] == cieb_pkg::GRP_MOVE &&
                   instr.b1[2:0] == cieb_pkg::REG_MEM &&
                   instr.b1[5:3] != cieb_pkg::REG_MEM) begin
        op_d.kind = cieb_pkg::K_LOAD; // [RULE17]
        op_d.dst = instr.b1[5:3];
        op_d.tst = cieb_pkg::T_IDX; // [RULE17]
      end else if (instr.b1[7:6] == cieb_pkg::GRP_MOVE &&
                   instr.b1[5:3] == cieb_pkg::REG_MEM &&
                   instr.b1[2:0] != cieb_pkg::REG_MEM) begin
        op_d.kind = cieb_pkg::K_STORE; // [RULE16]
        op_d.val = gpr_q[instr.b1[2:0]];
        op_d.tst = cieb_pkg::T_IDX; // [RULE16]
      end
    end else if (instr.b0 == cieb_pkg::OP_PFX_ED) begin
      op_d.m1s = 2'h2;
      op_d.tst = cieb_pkg::T_SPEC;
      op_d.dst = cieb_pkg::REG_A;
      case (instr.b1)
        cieb_pkg::OP_ACC_VEC: begin
          op_d.kind = cieb_pkg::K_REGF; // [RULE10]
          op_d.val = vector_reg_q;
        end
        cieb_pkg::OP_ACC_REF: begin
          op_d.kind = cieb_pkg::K_REGF; // [RULE11]
          op_d.val = refresh_reg_q;
        end
        cieb_pkg::OP_VEC_ACC: begin
          op_d.kind = cieb_pkg::K_SETV; // [RULE12]
          op_d.val = gpr_q[cieb_pkg::REG_A];
        end
        cieb_pkg::OP_REF_ACC: begin
          op_d.kind = cieb_pkg::K_SETR; // [RULE13]
          op_d.val = gpr_q[cieb_pkg::REG_A];
        end
        cieb_pkg::OP_RETURN_FROM_NONMASKABLE: begin
          op_d.kind = cieb_pkg::K_RETURN_FROM_NONMASKABLE;
          op_d.tst = cieb_pkg::T_RETURN_FROM_NONMASKABLE;
        end
        default: begin
          op_d.tst = cieb_pkg::T_CTRL;
        end
      endcase
    end else if (instr.b0 == cieb_pkg::OP_DI) begin
      op_d.kind = cieb_pkg::K_DI;
    end else if (instr.b0 == cieb_pkg::OP_EI) begin
      op_d.kind = cieb_pkg::K_EI;
    end else if (instr.b0 == cieb_pkg::OP_ACC_DIR ||
                 instr.b0 == cieb_pkg::OP_DIR_ACC) begin
      op_d.kind = (instr.b0 == cieb_pkg::OP_ACC_DIR) ? cieb_pkg::K_LOAD
                                                     : cieb_pkg::K_STORE;
      op_d.dst = cieb_pkg::REG_A;
      op_d.val = gpr_q[cieb_pkg::REG_A];
      op_d.addr = {instr.b2, instr.b1}; // [RULE18]
      op_d.tst = cieb_pkg::T_DIR; // [RULE18]
    end else if (instr.b0 == cieb_pkg::OP_ACC_BC ||
                 instr.b0 == cieb_pkg::OP_ACC_DE ||
                 instr.b0 == cieb_pkg::OP_BC_ACC ||
                 instr.b0 == cieb_pkg::OP_DE_ACC) begin
      op_d.kind = instr.b0[3] ? cieb_pkg::K_LOAD : cieb_pkg::K_STORE;
      op_d.dst = cieb_pkg::REG_A;
      op_d.val = gpr_q[cieb_pkg::REG_A];
      op_d.addr = instr.b0[4] ?
        {gpr_q[cieb_pkg::REG_D], gpr_q[cieb_pkg::REG_E]} :
        {gpr_q[cieb_pkg::REG_B], gpr_q[cieb_pkg::REG_C]};
      op_d.tst = cieb_pkg::T_IND;
    end else if (instr.b0 == cieb_pkg::OP_MEM_IMM) begin
      op_d.kind = cieb_pkg::K_STORE;
      op_d.val = instr.b1;
      op_d.addr = ptr;
      op_d.tst = cieb_pkg::T_IMM_HL;
    end else if (instr.b0[7:6] == cieb_pkg::GRP_MOVE) begin
      op_d.dst = instr.b0[5:3]; // [RULE15]
      op_d.addr = ptr;
      op_d.val = gpr_q[instr.b0[2:0]]; // [RULE15]
      if (instr.b0[2:0] == cieb_pkg::REG_MEM &&
          instr.b0[5:3] != cieb_pkg::REG_MEM) begin
        op_d.kind = cieb_pkg::K_LOAD;
        op_d.tst = cieb_pkg::T_IND;
      end else if (instr.b0[5:3] == cieb_pkg::REG_MEM &&
                   instr.b0[2:0] != cieb_pkg::REG_MEM) begin
        op_d.kind = cieb_pkg::K_STORE; // [RULE16]
        op_d.tst = cieb_pkg::T_IND;
      end else if (instr.b0[5:3] != cieb_pkg::REG_MEM) begin
        op_d.kind = cieb_pkg::K_REG; // [RULE14]
        op_d.tst = cieb_pkg::T_REG; // [RULE14]
      end
    end else if (instr.b0[7:6] == cieb_pkg::GRP_ZERO &&
                 instr.b0[2:0] == cieb_pkg::REG_MEM &&
                 instr.b0[5:3] != cieb_pkg::REG_MEM) begin
      op_d.kind = cieb_pkg::K_REG; // [RULE14]
      op_d.dst = instr.b0[5:3];
      op_d.val = instr.b1;
      op_d.tst = cieb_pkg::T_IMM; // [RULE14]
    end
  end

  // Sequencer; an interrupt waits for the current instruction to end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= cieb_pkg::S_IDLE;
      instr_ready_q <= 1'b1;
      cnt_q <= '0;
      op_q <= '0;
    end else begin
      case (state_q)
        cieb_pkg::S_IDLE: begin
          if (take) begin
            state_q <= cieb_pkg::S_EXEC;
            instr_ready_q <= 1'b0;
            op_q <= op_d;
            cnt_q <= op_d.tst - cieb_pkg::CNT_LAST;
          end else if (irq_go) begin
            state_q <= cieb_pkg::S_ACK; // [RULE4]
            instr_ready_q <= 1'b0;
          end
        end
        cieb_pkg::S_EXEC: begin
          cnt_q <= cnt_q - cieb_pkg::CNT_LAST;
          if (last) begin
            state_q <= irq_go ? cieb_pkg::S_ACK : cieb_pkg::S_IDLE;
            instr_ready_q <= ~irq_go;
          end
        end
        default: begin
          state_q <= cieb_pkg::S_IDLE;
          instr_ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_ack_q <= 1'b0;
      int_ack_q <= 1'b0;
    end else begin
      nmi_ack_q <= nmi_take; // [RULE6]
      int_ack_q <= int_take;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= last;
      illegal_q <= last && op_q.kind == cieb_pkg::K_BAD;
    end
  end

  // Strobe one cycle ahead of the end so the read data lands at the end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_q <= '0;
    end else begin
      mem_q.rd <= 1'b0;
      mem_q.wr <= 1'b0;
      if (state_q == cieb_pkg::S_EXEC && cnt_q == cieb_pkg::CNT_MEM) begin
        mem_q.rd <= op_q.kind == cieb_pkg::K_LOAD;
        mem_q.wr <= op_q.kind == cieb_pkg::K_STORE;
        mem_q.addr <= op_q.addr;
        mem_q.wdata <= op_q.val;
      end
    end
  end

  assign res = (op_q.kind == cieb_pkg::K_LOAD) ? mem_rdata : op_q.val;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpr_q <= '0;
    end else if (last && (op_q.kind == cieb_pkg::K_REG ||
                          op_q.kind == cieb_pkg::K_REGF ||
                          op_q.kind == cieb_pkg::K_LOAD)) begin
      gpr_q[op_q.dst] <= res;
    end
  end

  // Carry and undocumented bits are left alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= cieb_pkg::RST_FLAGS;
    end else if (last && op_q.kind == cieb_pkg::K_REGF) begin
      flags_q[cieb_pkg::F_S] <= res[7]; // [RULE8] [RULE9]
      flags_q[cieb_pkg::F_Z] <= res == 8'h00; // [RULE8] [RULE9]
      flags_q[cieb_pkg::F_H] <= 1'b0; // [RULE8] [RULE9]
      flags_q[cieb_pkg::F_N] <= 1'b0; // [RULE8] [RULE9]
      flags_q[cieb_pkg::F_PV] <= secondary_int_enable_q; // [RULE8] [RULE9]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vector_reg_q <= cieb_pkg::RST_BYTE;
    end else if (last && op_q.kind == cieb_pkg::K_SETV) begin
      vector_reg_q <= op_q.val; // [RULE12]
    end
  end

  // Low seven bits count opcode fetches; bit 7 only changes by a load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refresh_reg_q <= cieb_pkg::RST_BYTE;
    end else if (last && op_q.kind == cieb_pkg::K_SETR) begin
      refresh_reg_q <= op_q.val; // [RULE13]
    end else if (take) begin
      refresh_reg_q[6:0] <= refresh_reg_q[6:0] + {5'h00, op_d.m1s};
    end
  end
endmodule : cieb_core

// File: verif/cieb_monitor.sv
// Concurrent checks on the ports of the byte-load and enable core.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module cieb_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire cieb_pkg::cieb_instr_t instr,
  input wire logic instr_valid,
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] second_index_register,
  input wire logic [7:0] mem_rdata,
  input wire logic nmi_req,
  input wire logic int_req,
  input wire logic instr_ready_q,
  input wire logic done_q,
  input wire logic illegal_q,
  input wire cieb_pkg::cieb_mem_t mem_q,
  input wire logic nmi_ack_q,
  input wire logic int_ack_q,
  input wire logic [7:0][7:0] gpr_q,
  input wire logic [7:0] flags_q,
  input wire logic [7:0] vector_reg_q,
  input wire logic [7:0] refresh_reg_q,
  input wire logic primary_int_enable_q,
  input wire logic secondary_int_enable_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = instr_valid && instr_ready_q;
  wire logic [7:0] op = instr.b0;
  wire logic [7:0] op2 = instr.b1;
  wire logic pfx = tk && op == 8'hED;
  wire logic mv = tk && op[7:6] == 2'h1 && op[5:3] != 3'h6 && op[2:0] != 3'h6;
  wire logic [7:0] dsp = instr.b2;
  wire logic [15:0] ea_a = first_index_register + {{8{dsp[7]}}, dsp};
  wire logic [15:0] ea_b = second_index_register + {{8{dsp[7]}}, dsp};
  wire logic [15:0] dir_a = {instr.b2, instr.b1};
  wire logic [7:0] st_val = gpr_q[op2[2:0]];
  wire logic [7:0] acc = gpr_q[7];
  wire logic sp_ok = flags_q[7] == acc[7] && flags_q[6] == (acc == 8'h00)
    && !flags_q[4] && flags_q[2] == secondary_int_enable_q && !flags_q[1];
  chk_move_time: assert property (
    mv |=> !done_q [*3] ##1 done_q) else $error("move length wrong");
  chk_vec_read: assert property (
    pfx && op2 == 8'h57 |=> !done_q [*8] ##1 done_q && sp_ok
    && flags_q[0] == $past(flags_q[0], 9)) else $error("vector read wrong");
  chk_ref_read: assert property (
    pfx && op2 == 8'h5F |-> ##9 done_q && sp_ok)
    else $error("refresh read wrong");
  chk_vec_write: assert property (
    pfx && op2 == 8'h47 |-> ##9 done_q && vector_reg_q == $past(acc, 9)
    && flags_q == $past(flags_q, 9)) else $error("vector write wrong");
  chk_ref_write: assert property (
    pfx && op2 == 8'h4F |-> ##9 done_q && flags_q == $past(flags_q, 9))
    else $error("refresh write wrong");
  chk_direct_load: assert property (
    tk && op == 8'h3A |-> ##11 mem_q.rd && mem_q.addr == $past(dir_a, 11)
    ##2 done_q && acc == $past(mem_rdata, 1)
    && flags_q == $past(flags_q, 13)) else $error("direct load wrong");
  chk_index_load: assert property (
    tk && op == 8'hFD && op2[7:6] == 2'h1 && op2[2:0] == 3'h6
    |-> ##17 mem_q.rd && mem_q.addr == $past(ea_b, 17) ##2 done_q)
    else $error("second index load wrong");
  chk_index_store: assert property (
    tk && op == 8'hDD && op2[7:3] == 5'h0E && op2[2:0] != 3'h6
    |-> ##17 mem_q.wr && mem_q.addr == $past(ea_a, 17)
    && mem_q.wdata == $past(st_val, 17) ##2 done_q)
    else $error("first index store wrong");
  chk_nmi_copy: assert property (
    nmi_ack_q |-> !primary_int_enable_q
    && secondary_int_enable_q == $past(primary_int_enable_q))
    else $error("nonmaskable accept wrong");
  chk_int_gate: assert property (
    int_ack_q |-> $past(primary_int_enable_q) && !primary_int_enable_q)
    else $error("masked request accepted");
  chk_en_set: assert property (
    tk && op == 8'hFB |-> ##5 primary_int_enable_q || int_ack_q
    || nmi_ack_q) else $error("enable not set");
  chk_dis_clear: assert property (
    tk && op == 8'hF3 |-> ##5 !primary_int_enable_q
    && !secondary_int_enable_q) else $error("enable not cleared");
  chk_nmi_queue: assert property (
    nmi_req |-> ##[1:24] nmi_ack_q) else $error("nonmaskable lost");
  chk_return_from_nonmaskable_back: assert property (
    pfx && op2 == 8'h45 |-> ##15 nmi_ack_q || int_ack_q
    || primary_int_enable_q == secondary_int_enable_q)
    else $error("return did not restore");
  cov_nmi: cover property (nmi_ack_q);
  cov_int: cover property (int_ack_q);
  cov_idx: cover property (tk && op == 8'hFD);
endmodule : cieb_monitor

bind cieb_core cieb_monitor cieb_monitor_inst (.clk(clk), .rst_n(rst_n),
  .instr(instr), .instr_valid(instr_valid),
  .first_index_register(first_index_register),
  .second_index_register(second_index_register), .mem_rdata(mem_rdata),
  .nmi_req(nmi_req), .int_req(int_req), .instr_ready_q(instr_ready_q),
  .done_q(done_q), .illegal_q(illegal_q), .mem_q(mem_q),
  .nmi_ack_q(nmi_ack_q), .int_ack_q(int_ack_q), .gpr_q(gpr_q),
  .flags_q(flags_q), .vector_reg_q(vector_reg_q),
  .refresh_reg_q(refresh_reg_q),
  .primary_int_enable_q(primary_int_enable_q),
  .secondary_int_enable_q(secondary_int_enable_q));

// File: verif/cieb_periph_model.sv
// Far side: program memory and a three-place interrupt priority chain.
// Assumes one-cycle read strobes; data follows on the next cycle.
`timescale 1ns/1ps
module cieb_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire cieb_pkg::cieb_mem_t mem_q,
  input wire logic int_ack_q,
  input wire logic [2:0] raise,
  input wire logic [2:0] served,
  output logic [7:0] mem_rdata,
  output logic int_req,
  output logic [2:0] srv_q
);
  logic [2:0] pend_q;
  logic [2:0] chain_enable_in;
  logic [2:0] chain_enable_out;
  logic [2:0] pick;
  // First place tied high; each later place ranks lower
  assign chain_enable_in = {chain_enable_out[1:0], 1'h1};
  // Held low from request until service ends
  assign chain_enable_out = chain_enable_in & ~(pend_q | srv_q);
  assign pick = int_ack_q ? (pend_q & chain_enable_in) : 3'h0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 3'h0;
      srv_q <= 3'h0;
      int_req <= 1'h0;
    end else begin
      pend_q <= (pend_q | raise) & ~pick;
      srv_q <= (srv_q | pick) & ~served;
      int_req <= |raise;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rdata <= 8'hA5;
    end else if (mem_q.rd) begin
      mem_rdata <= mem_q.addr[7:0] ^ mem_q.addr[15:8] ^ 8'h5A;
    end else begin
      // Idle bus negates the byte each cycle so a sample one cycle late differs unless the byte is 00 or 80
      mem_rdata <= ~mem_rdata + 8'h01;
    end
  end
endmodule : cieb_periph_model

// File: verif/tb_top.sv
// Self-checking bench for the core with the memory and chain model.
// Assumes 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst_n;
  cieb_pkg::cieb_instr_t instr;
  logic instr_valid;
  logic [15:0] idx_a;
  logic [15:0] idx_b;
  logic nmi_req;
  logic [2:0] raise;
  logic [2:0] served;
  logic [7:0] mem_rdata;
  logic int_req, ready, done, illegal, nmi_ack, int_ack, pen, sen;
  cieb_pkg::cieb_mem_t mem_q;
  logic [7:0][7:0] gpr;
  logic [7:0] flags, vreg, rreg, v, fl;
  logic [2:0] srv, s, d;
  logic [15:0] a;
  logic [7:0] shadow [8];
  logic [31:0] rng = 32'h575F;
  int n_errors = 0;
  int compares = 0;
  cieb_core cieb_core_inst (.clk(clk), .rst_n(rst_n), .instr(instr),
    .instr_valid(instr_valid), .first_index_register(idx_a),
    .second_index_register(idx_b), .mem_rdata(mem_rdata),
    .nmi_req(nmi_req), .int_req(int_req), .instr_ready_q(ready),
    .done_q(done), .illegal_q(illegal), .mem_q(mem_q),
    .nmi_ack_q(nmi_ack), .int_ack_q(int_ack), .gpr_q(gpr),
    .flags_q(flags), .vector_reg_q(vreg), .refresh_reg_q(rreg),
    .primary_int_enable_q(pen), .secondary_int_enable_q(sen));
  cieb_periph_model cieb_periph_model_inst (.clk(clk), .rst_n(rst_n),
    .mem_q(mem_q), .int_ack_q(int_ack), .raise(raise), .served(served),
    .mem_rdata(mem_rdata), .int_req(int_req), .srv_q(srv));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd
  function automatic logic [7:0] mem_byte(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction : mem_byte
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Offers one bundle, then counts cycles from take to done
  task automatic run(input logic [31:0] code, input int t);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'h1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    instr = code;
    instr_valid = 1'h1;
    @(negedge clk);
    instr_valid = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    check(n, t);
  endtask : run
  task automatic wait_ack();
    int n;
    n = 0;
    while (nmi_ack !== 1'h1 && int_ack !== 1'h1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    check(n < 40, 1);
  endtask : wait_ack
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'h0;
    instr = '0;
    instr_valid = 1'h0;
    nmi_req = 1'h0;
    raise = 3'h0;
    served = 3'h0;
    idx_a = 16'h1200;
    idx_b = 16'h3480;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    check({pen, sen, ready, flags}, {3'h1, 8'h00});
    for (int k = 0; k < 8; k++) begin
      if (k != 6) begin
        v = rnd();
        s = k[2:0];
        run({16'h0, v, 2'h0, s, 3'h6}, 7);
        shadow[s] = v;
        check(gpr[s], v);
      end
    end
    repeat (20) begin
      v = rnd();
      s = (v[2:0] == 3'h6) ? 3'h7 : v[2:0];
      d = (v[5:3] == 3'h6) ? 3'h7 : v[5:3];
      run({24'h0, 2'h1, d, s}, 4);
      shadow[d] = shadow[s];
      check(gpr[d], shadow[d]);
    end
    $display("loads and moves done");
    a = {rnd(), rnd()};
    fl = flags;
    run({8'h0, a, 8'h3A}, 13);
    check({gpr[7], flags}, {mem_byte(a), fl});
    foreach (shadow[k]) begin
      if (k == 0 || k == 3) begin
        v = (k == 0) ? 8'h80 : 8'h7F;
        run({8'h0, v, 2'h1, 3'h2, 3'h6, 8'hFD}, 19);
        check(gpr[2], mem_byte(idx_b + {{8{v[7]}}, v}));
      end
    end
    run({8'h0, 8'hFE, 5'h0E, 3'h1, 8'hDD}, 19);
    check({mem_q.addr, mem_q.wdata}, {idx_a - 16'h0002, shadow[1]});
    run({24'h0, 5'h0E, 3'h3}, 7);
    check({mem_q.addr, mem_q.wdata}, {shadow[4], shadow[5], shadow[3]});
    run(32'h76, 4);
    check(illegal, 1'h1);
    $display("memory forms done");
    for (int k = 0; k < 2; k++) begin
      v = k[0] ? 8'h80 : 8'h00;
      run({16'h0, v, 8'h3E}, 7);
      run(32'h000047ED, 9);
      check(vreg, v);
      run(32'h00004FED, 9);
      check(rreg, v);
      fl = flags;
      run(k[0] ? 32'hFB : 32'hF3, 4);
      @(negedge clk);
      check({pen, sen}, {2{k[0]}});
      run(32'h000057ED, 9);
      check(flags & 8'hD7, {v[7], v == 8'h00, 3'h0, k[0], 1'h0, fl[0]});
      run(32'h00005FED, 9);
      check(flags & 8'h16, {5'h0, k[0], 2'h0});
    end
    $display("special loads done");
    nmi_req = 1'h1;
    @(negedge clk);
    nmi_req = 1'h0;
    wait_ack();
    check({nmi_ack, pen, sen}, 3'h5);
    run(32'h000045ED, 14);
    @(negedge clk);
    check({pen, sen}, 2'h3);
    run(32'hF3, 4);
    raise = 3'h4;
    @(negedge clk);
    raise = 3'h1;
    @(negedge clk);
    raise = 3'h0;
    repeat (6) @(negedge clk);
    check(srv, 3'h0);
    run(32'hFB, 4);
    wait_ack();
    check({int_ack, pen, sen}, 3'h4);
    @(negedge clk);
    check(srv, 3'h1);
    served = 3'h1;
    @(negedge clk);
    served = 3'h0;
    run(32'hFB, 4);
    wait_ack();
    check(int_ack, 1'h1);
    @(negedge clk);
    check(srv, 3'h4);
    $display("interrupts done");
    end_sim();
  end
endmodule : tb_top
